// >>> hdl/tspwm_consts.vh
// register offsets, field positions, reset values and encodings of the single-pulse / pwm timer
`ifndef TSPWM_CONSTS_VH
`define TSPWM_CONSTS_VH

// ****************************************
// register word addresses (each value is compared directly with avs_address)
// ****************************************
`define TSPWM_OFF_CTRL      4'h0
`define TSPWM_OFF_FILT      4'h1
`define TSPWM_OFF_DEADT     4'h2
`define TSPWM_OFF_RELOAD    4'h3
`define TSPWM_OFF_COUNT     4'h4
`define TSPWM_OFF_CMPA      4'h5
`define TSPWM_OFF_CMPB      4'h6
`define TSPWM_OFF_STATUS    4'h7

// ****************************************
// timer_control_reg fields
// ****************************************
`define TSPWM_CR_EN         0
`define TSPWM_CR_MODE_LO    1
`define TSPWM_CR_MODE_HI    2
`define TSPWM_CR_DIR        3
`define TSPWM_CR_COMP       4
`define TSPWM_CR_TWOPT      5
`define TSPWM_CR_SHOT       6
`define TSPWM_CR_SLAVE      7
`define TSPWM_CR_BUFA       8
`define TSPWM_CR_BUFB       9
`define TSPWM_CR_RESET      10'h020

// ****************************************
// output_filter_reg fields
// ****************************************
`define TSPWM_FL_MODEA_LO   0
`define TSPWM_FL_MODEA_HI   2
`define TSPWM_FL_MODEB_LO   4
`define TSPWM_FL_MODEB_HI   6
`define TSPWM_FL_POLA       3
`define TSPWM_FL_POLB       7
`define TSPWM_FL_RESET      8'h00

// ****************************************
// dead_time_reg fields
// ****************************************
`define TSPWM_DT_MOE        0

// ****************************************
// encodings
// ****************************************
`define TSPWM_MODE_EDGE     2'h2
`define TSPWM_MODE_CENTER   2'h3
`define TSPWM_OCM_FLOW      3'h0
`define TSPWM_OCM_FHIGH     3'h1
`define TSPWM_OCM_MCLR      3'h2
`define TSPWM_OCM_MSET      3'h3
`define TSPWM_OCM_MTOG      3'h4
`define TSPWM_OCM_MPULSE    3'h5
`define TSPWM_OCM_PWM1      3'h6
`define TSPWM_OCM_PWM2      3'h7

`endif

// >>> hdl/tspwm_timer.v
// single-pulse and independent pwm output timer with an avalon-mm register slave
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// R1: single_shot_select set: counter stops at next update event.
// R2: software puts timer in slave mode and a compare mode before single pulse.
// R3: single pulse up: counter below compare, compare not above reload.
// R4: single pulse down: counter above compare.
// R5: single pulse: counting starts on trigger edge, one positive pulse results.
// R6: delay is counter start to compare; width is compare to reload.
// R7: pwm period from auto_reload_value, duty from channel_compare_value.
// R8: comp field 0 selects independent pwm; mode 110 pwm1, 111 pwm2.
// R9: pwm reaches pins only while main_output_enable is 1.
// R10: channel a uses single or double compare per two_point_select.
// R11: two_point_select 0 enables double compare on channel a.
// R12: channel b always single compare from compare_value_b.
// R13: single, up: mode 1 high while counter below compare; mode 2 inverse.
// R14: single, down: mode 1 low while counter above compare; mode 2 inverse.
// R15: double edge up: mode1 low a<cnt<=b; mode2 high a<=cnt<b.
// R16: double edge down: mode1 high a<cnt<=b; mode2 low a<=cnt<b.
// R17: double center up: by compare a, mode1 high below a, mode2 low.
// R18: double center down: by compare b, mode1 low above b, mode2 high.
// R19: counting mode 0x2 edge-aligned, 0x3 center-aligned.
// R20: edge-aligned direction 0x0 up, 0x1 down.
// R21: polarity 0 passes reference, 1 inverts it.
// R22: software loads counter below reload before setting enable.
// R23: software enables peripheral clock before configuring the timer.
// R24: buffered compare takes effect at update event, else immediately.
// R25: update event at reload when up, at zero when down; in center-aligned mode the code updates only at zero on the way down.

module tspwm_timer #(
	parameter WIDTH = 16
) (
	input  wire             clk,
	input  wire             reset_n,
	input  wire             clk_en,
	input  wire [3:0]       avs_address,
	input  wire             avs_read,
	input  wire             avs_write,
	input  wire [31:0]      avs_writedata,
	input  wire [3:0]       avs_byteenable,
	output reg  [31:0]      avs_readdata,
	output wire             avs_waitrequest,
	input  wire             trigger_in,
	output reg              channel_out_a,
	output reg              channel_out_b,
	output wire             channel_oe_a,
	output wire             channel_oe_b
);

`include "tspwm_consts.vh"

	// ****************************************
	// registers
	// ****************************************
	reg  [9:0]       ctrl_q;
	reg  [7:0]       filt_q;
	reg              moe_q;
	reg  [WIDTH-1:0] reload_q;
	reg  [WIDTH-1:0] count_q;
	reg  [WIDTH-1:0] cmpa_wr_q;
	reg  [WIDTH-1:0] cmpb_wr_q;
	reg  [WIDTH-1:0] cmpa_q;
	reg  [WIDTH-1:0] cmpb_q;
	reg              dir_cnt_q;
	reg              armed_q;
	reg              stopped_q;
	reg              rd_pend_q;
	reg  [2:0]       trig_sync_q;
	reg              trig_seen_q;

	wire             enable     = ctrl_q[`TSPWM_CR_EN];
	wire [1:0]       cmode      = ctrl_q[`TSPWM_CR_MODE_HI:`TSPWM_CR_MODE_LO];
	wire             center     = (cmode == `TSPWM_MODE_CENTER); // R19
	wire             edge_down  = ctrl_q[`TSPWM_CR_DIR] && !center; // R20
	wire             comp_sel   = ctrl_q[`TSPWM_CR_COMP];
	wire             two_point  = !ctrl_q[`TSPWM_CR_TWOPT]; // R11
	wire             single     = ctrl_q[`TSPWM_CR_SHOT];
	wire             slave      = ctrl_q[`TSPWM_CR_SLAVE];
	wire [2:0]       ocm_a      = filt_q[`TSPWM_FL_MODEA_HI:`TSPWM_FL_MODEA_LO];
	wire [2:0]       ocm_b      = filt_q[`TSPWM_FL_MODEB_HI:`TSPWM_FL_MODEB_LO];

	// ****************************************
	// avalon slave: writes in one cycle, reads take one wait cycle
	// ****************************************
	wire             wr_en      = avs_write && clk_en;
	wire             rd_done    = avs_read && rd_pend_q;
	assign avs_waitrequest = (avs_read && !rd_pend_q) || !clk_en;

	function [31:0] be_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  be;
		integer i;
		begin
			be_merge = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i])
					be_merge[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	endfunction

	function [31:0] widen;
		input [WIDTH-1:0] v;
		begin
			widen = 32'h00000000;
			widen[WIDTH-1:0] = v;
		end
	endfunction

	wire [31:0] wdat_ctrl   = be_merge({22'h000000, ctrl_q}, avs_writedata, avs_byteenable);
	wire [31:0] wdat_filt   = be_merge({24'h000000, filt_q}, avs_writedata, avs_byteenable);
	wire [31:0] wdat_reload = be_merge(widen(reload_q), avs_writedata, avs_byteenable);
	wire [31:0] wdat_count  = be_merge(widen(count_q), avs_writedata, avs_byteenable);
	wire [31:0] wdat_cmpa   = be_merge(widen(cmpa_wr_q), avs_writedata, avs_byteenable);
	wire [31:0] wdat_cmpb   = be_merge(widen(cmpb_wr_q), avs_writedata, avs_byteenable);

	wire wr_ctrl   = wr_en && (avs_address == `TSPWM_OFF_CTRL);
	wire wr_filt   = wr_en && (avs_address == `TSPWM_OFF_FILT);
	wire wr_deadt  = wr_en && (avs_address == `TSPWM_OFF_DEADT) && avs_byteenable[0];
	wire wr_reload = wr_en && (avs_address == `TSPWM_OFF_RELOAD);
	wire wr_count  = wr_en && (avs_address == `TSPWM_OFF_COUNT);
	wire wr_cmpa   = wr_en && (avs_address == `TSPWM_OFF_CMPA);
	wire wr_cmpb   = wr_en && (avs_address == `TSPWM_OFF_CMPB);

	// ****************************************
	// trigger input synchroniser and edge detect
	// ****************************************
	wire trig_level = trig_sync_q[2];
	wire trig_agree = (trig_sync_q[1] == trig_sync_q[2]);
	wire trig_rise  = trig_agree && trig_sync_q[1] && !trig_seen_q;

	// ****************************************
	// counter and update event
	// ****************************************
	wire at_top    = (count_q >= reload_q);
	wire at_zero   = (count_q == {WIDTH{1'b0}});
	wire running   = enable && !stopped_q && (!slave || armed_q);
	wire going_dn  = center ? dir_cnt_q : edge_down;
	// R25
	wire update_ev = running && (center ? (going_dn && at_zero) : (going_dn ? at_zero : at_top));

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trig_sync_q <= 3'h0;
			trig_seen_q <= 1'b0;
		end else if (clk_en) begin
			trig_sync_q <= {trig_sync_q[1:0], trigger_in};
			if (trig_agree)
				trig_seen_q <= trig_level;
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q   <= {WIDTH{1'b0}};
			dir_cnt_q <= 1'b0;
			armed_q   <= 1'b0;
			stopped_q <= 1'b0;
		end else if (clk_en) begin
			if (!enable || wr_ctrl) begin
				stopped_q <= 1'b0;
				armed_q   <= 1'b0;
			end else if (slave && trig_rise && !armed_q) begin
				armed_q <= 1'b1; // R5
			end
			if (wr_count) begin
				count_q <= wdat_count[WIDTH-1:0];
			end else if (running) begin
				if (update_ev && single) begin
					stopped_q <= 1'b1; // R1
					armed_q   <= 1'b0;
				end
				if (center) begin
					if (!dir_cnt_q && at_top) begin
						dir_cnt_q <= 1'b1;
						count_q   <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
					end else if (dir_cnt_q && at_zero) begin
						dir_cnt_q <= 1'b0;
						count_q   <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
					end else if (dir_cnt_q) begin
						count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
					end else begin
						count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
					end
				end else if (edge_down) begin
					count_q <= at_zero ? reload_q : count_q - {{(WIDTH-1){1'b0}}, 1'b1}; // R7
				end else begin
					count_q <= at_top ? {WIDTH{1'b0}} : count_q + {{(WIDTH-1){1'b0}}, 1'b1}; // R7
				end
			end
		end
	end

	// ****************************************
	// register file and compare shadow
	// ****************************************
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q    <= `TSPWM_CR_RESET;
			filt_q    <= `TSPWM_FL_RESET;
			moe_q     <= 1'b0;
			reload_q  <= {WIDTH{1'b1}};
			cmpa_wr_q <= {WIDTH{1'b0}};
			cmpb_wr_q <= {WIDTH{1'b0}};
			cmpa_q    <= {WIDTH{1'b0}};
			cmpb_q    <= {WIDTH{1'b0}};
			rd_pend_q <= 1'b0;
		end else if (clk_en) begin
			rd_pend_q <= avs_read && !rd_pend_q;
			if (wr_ctrl)
				ctrl_q <= wdat_ctrl[9:0];
			if (wr_filt)
				filt_q <= wdat_filt[7:0];
			if (wr_deadt)
				moe_q <= avs_writedata[`TSPWM_DT_MOE];
			if (wr_reload)
				reload_q <= wdat_reload[WIDTH-1:0];
			if (wr_cmpa)
				cmpa_wr_q <= wdat_cmpa[WIDTH-1:0];
			if (wr_cmpb)
				cmpb_wr_q <= wdat_cmpb[WIDTH-1:0];
			// shadow loads from the register being written as well, so no write is ever one update late
			if (wr_cmpa && !ctrl_q[`TSPWM_CR_BUFA])
				cmpa_q <= wdat_cmpa[WIDTH-1:0]; // R24
			else if (update_ev || !ctrl_q[`TSPWM_CR_BUFA])
				cmpa_q <= wr_cmpa ? wdat_cmpa[WIDTH-1:0] : cmpa_wr_q; // R24
			if (wr_cmpb && !ctrl_q[`TSPWM_CR_BUFB])
				cmpb_q <= wdat_cmpb[WIDTH-1:0]; // R24
			else if (update_ev || !ctrl_q[`TSPWM_CR_BUFB])
				cmpb_q <= wr_cmpb ? wdat_cmpb[WIDTH-1:0] : cmpb_wr_q; // R24
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= 32'h00000000;
		end else if (clk_en && avs_read && !rd_pend_q) begin
			case (avs_address)
			`TSPWM_OFF_CTRL:   avs_readdata <= {22'h000000, ctrl_q};
			`TSPWM_OFF_FILT:   avs_readdata <= {24'h000000, filt_q};
			`TSPWM_OFF_DEADT:  avs_readdata <= {31'h00000000, moe_q};
			`TSPWM_OFF_RELOAD: avs_readdata <= widen(reload_q);
			`TSPWM_OFF_COUNT:  avs_readdata <= widen(count_q);
			`TSPWM_OFF_CMPA:   avs_readdata <= widen(cmpa_wr_q);
			`TSPWM_OFF_CMPB:   avs_readdata <= widen(cmpb_wr_q);
			`TSPWM_OFF_STATUS: avs_readdata <= {28'h0000000, going_dn, armed_q, stopped_q, running};
			default:           avs_readdata <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// reference waveform generation
	// ****************************************
	// single-point pwm: output high means "mode 1 active" with pwm2 low, "mode 1 inactive" with pwm2 high
	function single_ref;
		input             pwm2;
		input             down;
		input [WIDTH-1:0] cnt;
		input [WIDTH-1:0] cmp;
		begin
			if (down)
				single_ref = pwm2 ? (cnt > cmp) : !(cnt > cmp); // R14
			else
				single_ref = pwm2 ? !(cnt < cmp) : (cnt < cmp); // R13
		end
	endfunction

	// match-based modes act on equality; forced modes ignore the counter
	function cmp_ref;
		input [2:0]       ocm;
		input             prev;
		input             down;
		input [WIDTH-1:0] cnt;
		input [WIDTH-1:0] cmp;
		begin
			case (ocm)
			`TSPWM_OCM_FLOW:   cmp_ref = 1'b0;
			`TSPWM_OCM_FHIGH:  cmp_ref = 1'b1;
			`TSPWM_OCM_MCLR:   cmp_ref = (cnt == cmp) ? 1'b0 : prev;
			`TSPWM_OCM_MSET:   cmp_ref = (cnt == cmp) ? 1'b1 : prev;
			`TSPWM_OCM_MTOG:   cmp_ref = (cnt == cmp) ? !prev : prev;
			`TSPWM_OCM_MPULSE: cmp_ref = (cnt == cmp);
			default:           cmp_ref = single_ref(ocm[0], down, cnt, cmp); // R8
			endcase
		end
	endfunction

	reg ref_a_q;
	reg ref_b_q;
	reg ref_a_d;
	wire ref_b_d = cmp_ref(ocm_b, ref_b_q, going_dn, count_q, cmpb_q); // R12
	wire pwm_a   = (ocm_a == `TSPWM_OCM_PWM1) || (ocm_a == `TSPWM_OCM_PWM2); // R8
	wire pwm2_a  = (ocm_a == `TSPWM_OCM_PWM2);

	always @* begin
		ref_a_d = cmp_ref(ocm_a, ref_a_q, going_dn, count_q, cmpa_q); // R10
		if (pwm_a && two_point) begin
			if (center) begin
				if (!going_dn)
					ref_a_d = pwm2_a ? !(count_q < cmpa_q) : (count_q < cmpa_q); // R17
				else
					ref_a_d = pwm2_a ? (count_q > cmpb_q) : !(count_q > cmpb_q); // R18
			end else if (!going_dn) begin
				if (pwm2_a)
					ref_a_d = (count_q >= cmpa_q) && (count_q < cmpb_q); // R15
				else
					ref_a_d = !((count_q > cmpa_q) && (count_q <= cmpb_q)); // R15
			end else begin
				if (pwm2_a)
					ref_a_d = !((count_q >= cmpa_q) && (count_q < cmpb_q)); // R16
				else
					ref_a_d = (count_q > cmpa_q) && (count_q <= cmpb_q); // R16
			end
		end
	end

	// ****************************************
	// output stage
	// ****************************************
	// the single pulse ends with the counter stop, so the reference is held low once stopped
	wire hold_low  = single && (stopped_q || (slave && !armed_q)); // R5 R6
	wire route_ok  = moe_q && !comp_sel; // R8 R9

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_a_q       <= 1'b0;
			ref_b_q       <= 1'b0;
			channel_out_a <= 1'b0;
			channel_out_b <= 1'b0;
		end else if (clk_en) begin
			ref_a_q       <= hold_low ? 1'b0 : ref_a_d;
			ref_b_q       <= hold_low ? 1'b0 : ref_b_d;
			channel_out_a <= route_ok && ((hold_low ? 1'b0 : ref_a_d) ^ filt_q[`TSPWM_FL_POLA]); // R21
			channel_out_b <= route_ok && ((hold_low ? 1'b0 : ref_b_d) ^ filt_q[`TSPWM_FL_POLB]); // R21
		end
	end

	assign channel_oe_a = route_ok; // R9
	assign channel_oe_b = route_ok; // R9

endmodule

// >>> test/tb_timer_single_pulse_and_independent_pwm.sv
// self-checking bench for the pwm timer
`timescale 1ns/100ps
module tb_timer_single_pulse_and_independent_pwm;
	logic        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, trigger_in = 1'b0, clear = 1'b0;
	logic        avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0, rdata;
	wire  [31:0] avs_readdata, high_a, high_b, rise_a;
	wire         avs_waitrequest, out_a, out_b, oe_a, oe_b;
	int          num_errors = 0, compares = 0;

	always #4 clk = ~clk;

	tspwm_timer #(.WIDTH(16)) u_tspwm_timer (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trigger_in(trigger_in), .channel_out_a(out_a),
		.channel_out_b(out_b), .channel_oe_a(oe_a), .channel_oe_b(oe_b));
	tspwm_load u_tspwm_load (.clk(clk), .clear(clear), .pin_a(out_a), .oe_a(oe_a), .pin_b(out_b),
		.oe_b(oe_b), .high_a(high_a), .high_b(high_b), .rise_a(rise_a));

	// ****
	// shared tasks
	// ****
	task wrap_up;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	// one avalon transfer; the request stands until waitrequest is seen low
	task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_write <= w;
		avs_read <= ~w;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			num_errors++;
			wrap_up;
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task rd(input logic [3:0] a);
		xfer(1'b0, a, 32'h0);
	endtask

	// the load counts over a window that is a whole number of periods
	task measure(input int win);
		@(posedge clk);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (win) @(posedge clk);
		#1;
	endtask

	task run_pwm(input logic [31:0] ctrl, input logic [31:0] filt, input int win, input int ea, input int eb);
		wr(4'h0, 32'h0);
		wr(4'h1, filt);
		wr(4'h4, 32'h0);
		wr(4'h0, ctrl);
		repeat (20) @(posedge clk);
		measure(win);
		chk(32'(ea), high_a);
		chk(32'(eb), high_b);
	endtask

	// ****
	// scenarios
	// ****
	task t_regs;
		logic [31:0] exp_v [0:7];
		exp_v = '{32'h020, 32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 8; i++) begin
			rd(i == 7 ? 4'h8 : 4'(i));
			chk(exp_v[i], rdata);
		end
		wr(4'h9, 32'hffffffff);
		rd(4'h9);
		chk(32'h0, rdata);
		@(posedge clk);
		clk_en <= 1'b0;
		@(posedge clk);
		#1;
		chk(32'h1, {31'h0, avs_waitrequest});
		@(posedge clk);
		clk_en <= 1'b1;
		wr(4'h2, 32'h1);
		wr(4'h3, 32'h9);
		wr(4'h5, 32'h3);
		wr(4'h6, 32'h6);
		rd(4'h5);
		chk(32'h3, rdata);
		$display("t_regs done");
	endtask

	task t_single;
		run_pwm(32'h025, 32'h76, 100, 30, 40);
		run_pwm(32'h025, 32'hfe, 100, 70, 60);
		run_pwm(32'h02d, 32'h76, 100, 40, 30);
		run_pwm(32'h027, 32'h76, 90, 30, 30);
		$display("t_single done");
	endtask

	task t_double;
		run_pwm(32'h005, 32'h76, 100, 70, 40);
		run_pwm(32'h005, 32'h77, 100, 30, 40);
		run_pwm(32'h00d, 32'h76, 100, 30, 30);
		run_pwm(32'h00d, 32'h77, 100, 70, 30);
		run_pwm(32'h007, 32'h76, 90, 45, 30);
		$display("t_double done");
	endtask

	task t_gate;
		wr(4'h2, 32'h0);
		run_pwm(32'h025, 32'h76, 100, 0, 0);
		chk(32'h0, {31'h0, oe_a});
		wr(4'h2, 32'h1);
		run_pwm(32'h035, 32'h76, 100, 0, 0);
		chk(32'h0, {31'h0, oe_b});
		$display("t_gate done");
	endtask

	task t_shot;
		wr(4'h0, 32'h0);
		wr(4'h1, 32'h07);
		wr(4'h4, 32'h0);
		wr(4'h0, 32'h0e5);
		measure(30);
		chk(32'h0, high_a);
		@(posedge clk);
		trigger_in <= 1'b1;
		measure(60);
		chk(32'h7, high_a);
		chk(32'h1, rise_a);
		@(posedge clk);
		trigger_in <= 1'b0;
		repeat (4) @(posedge clk);
		trigger_in <= 1'b1;
		measure(40);
		chk(32'h0, high_a);
		rd(4'h7);
		chk(32'h2, rdata & 32'h3);
		// buffered compare: a new value written while idle must wait for the closing update
		wr(4'h0, 32'h1e5);
		wr(4'h5, 32'h5);
		trigger_in <= 1'b0;
		repeat (6) @(posedge clk);
		trigger_in <= 1'b1;
		measure(60);
		chk(32'h7, high_a);
		@(posedge clk);
		trigger_in <= 1'b0;
		$display("t_shot done");
	endtask

	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_regs;
		t_single;
		t_double;
		t_gate;
		t_shot;
		wrap_up;
	end
endmodule

// >>> test/tspwm_load.sv
// external load on the two channel pins
`timescale 1ns/100ps
module tspwm_load (
	input  wire         clk,
	input  wire         clear,
	input  wire         pin_a,
	input  wire         oe_a,
	input  wire         pin_b,
	input  wire         oe_b,
	output logic [31:0] high_a,
	output logic [31:0] high_b,
	output logic [31:0] rise_a
);
	// ****
	// pin level and pulse counting
	// ****
	// pull-downs: a released pin reads low, never the last driven level
	wire  lvl_a = oe_a & pin_a;
	wire  lvl_b = oe_b & pin_b;
	logic last_a = 1'b0;
	always @(posedge clk) begin
		last_a <= lvl_a;
		if (clear) begin
			high_a <= 32'h0;
			high_b <= 32'h0;
			rise_a <= 32'h0;
		end else begin
			high_a <= high_a + {31'h0, lvl_a};
			high_b <= high_b + {31'h0, lvl_b};
			rise_a <= rise_a + {31'h0, lvl_a & ~last_a};
		end
	end
endmodule

// >>> test/tspwm_timer_sva.sv
// port checker for the pwm timer
`timescale 1ns/100ps
module tspwm_chk (
	input wire        clk,
	input wire        reset_n,
	input wire        clk_en,
	input wire [3:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        channel_out_a,
	input wire        channel_out_b,
	input wire        channel_oe_a,
	input wire        channel_oe_b
);
	// ****
	// assertions
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_gate_out_a: assert property (!channel_oe_a && !$past(channel_oe_a) |-> !channel_out_a)
		else $error("channel a high while gated");
	a_gate_out_b: assert property (!channel_oe_b && !$past(channel_oe_b) |-> !channel_out_b)
		else $error("channel b high while gated");
	a_oe_pair: assert property (channel_oe_a == channel_oe_b)
		else $error("output enables differ");
	a_moe_off: assert property (avs_write && clk_en && avs_address == 4'h2 && avs_byteenable[0]
		&& !avs_writedata[0] |=> !channel_oe_a)
		else $error("output enable kept after clearing");
	a_comp_off: assert property (avs_write && clk_en && avs_address == 4'h0 && avs_byteenable[0]
		&& avs_writedata[4] |=> !channel_oe_a)
		else $error("output enable kept with complementary set");
	a_write_no_wait: assert property (avs_write && clk_en |-> !avs_waitrequest)
		else $error("write stalled");
	a_read_one_wait: assert property ($rose(avs_read) && clk_en |-> avs_waitrequest
		##1 (!avs_waitrequest || !clk_en))
		else $error("read answer late");
	a_clken_hold: assert property (!clk_en |-> avs_waitrequest)
		else $error("answer while clock disabled");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[3] |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_stands: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data moved without read");
	c_read: cover property (avs_read && !avs_waitrequest);
	c_oe_on: cover property ($rose(channel_oe_a));
	c_pulse: cover property ($rose(channel_out_a));
endmodule

bind tspwm_timer tspwm_chk u_tspwm_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .channel_out_a(channel_out_a), .channel_out_b(channel_out_b),
	.channel_oe_a(channel_oe_a), .channel_oe_b(channel_oe_b));
